//--- verilog/ccar_params.svh
// Purpose: constants for the core register and addressing block
// Assumes: included by the design file and the testbench
// Notes:   offsets are direct register space addresses
`ifndef CCAR_PARAMS_SVH
`define CCAR_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCAR_OFF_SP        8'h81
`define CCAR_OFF_WAIT      8'h92
`define CCAR_OFF_SPH       8'h9b
`define CCAR_OFF_ACTL      8'h9d
`define CCAR_OFF_ACT       8'hc5
`define CCAR_OFF_XREL      8'hc6
`define CCAR_OFF_TKEY1     8'hc7
`define CCAR_OFF_TKEY2     8'hcf
`define CCAR_OFF_PFLAGS    8'hd0
`define CCAR_OFF_PAGEHI    8'hda
`define CCAR_OFF_WORK      8'he0
`define CCAR_OFF_AUX       8'hf0
`define CCAR_DIRECT_BASE   8'h80

// ----------------------------------------
// reset values and keys
// ----------------------------------------
`define CCAR_RST_WAIT      8'h07
`define CCAR_KEY1          8'haa
`define CCAR_KEY2          8'h55
`define CCAR_TA_WINDOW     3'h4

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCAR_ACTL_VEC      5
`define CCAR_ACTL_PAGED    3
`define CCAR_ACTL_XSTK     2
`define CCAR_ACTL_AMHI     1
`define CCAR_ACTL_WMASK    8'h2b
`define CCAR_WAIT_MASK     8'h0f

// ----------------------------------------
// memory map
// ----------------------------------------
`define CCAR_XRAM_STEP     12
`define CCAR_VEC_HI_BASE   20'h07000
`define CCAR_BOOT_BASE     20'h07000
`define CCAR_KEY_FIRST     20'h06ff8
`define CCAR_KEY_LAST      20'h06fff
`define CCAR_PAGE_BYTES    512
`define CCAR_PAGE_COUNT    64
`define CCAR_PAGE_SHIFT    9
`define CCAR_BOOT_PAGE0    6'd56
`define CCAR_KEY_PAGE      6'd55
`define CCAR_IFB_CAL_LAST  7'h3f
`define CCAR_IFB_OTP_LAST  7'h7b

`endif

//--- verilog/ccar_pkg.sv
// Purpose: types for the core register and addressing block
// Assumes: nothing beyond the parameter header
// Notes:   fetch state machine encoding lives here
package ccar_pkg;

    // ----------------------------------------
    // fetch sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        CCAR_F_IDLE = 2'b00,
        CCAR_F_WAIT = 2'b01,
        CCAR_F_DONE = 2'b10
    } ccar_fetch_t;

    // ----------------------------------------
    // stack operation codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        CCAR_S_NONE = 2'b00,
        CCAR_S_PUSH = 2'b01,
        CCAR_S_POP  = 2'b10
    } ccar_stack_t;

endpackage

//--- verilog/ccar_regs.sv
// Purpose: core register set, stack, wait states and addressing control
// Assumes: one clock, direct register port driven by the executing core
// Notes:   all state in one struct; outputs come straight from flops
//
// Function
// - flash fetch waits equal wait field value
// - wait register resets to seven cycles
// - protected registers written only after key sequence
// - relocation value places xram in 4KB steps
// - mode20 gives 20-bit program, 16-bit stack
// - data addresses always sixteen bits wide
// - push writes at sp+1, pop reads sp
// - mode20 stack address is high:low pointer
// - priority activity flags follow interrupt service
// - uart activity flags at bits three to zero
// - program flags byte field layout
// - working and auxiliary registers bit addressable
// - flash is 64 pages of 512 bytes
// - boot pages 56-63 from 0x7000, page0 vectors
// - page 55 holds protection key bytes
// - info page split calibration, otp, not erasable
// - direct space 0x80-0xff directly addressable
// - addressing control field layout, resets zero
// - mode bits select 16 or 20 bit
// - vector select moves vectors to 0x7000
// - extended stack indicator is read only
// - paged high byte from port2 or page register
`timescale 1ns/1ns
`default_nettype none
`include "ccar_params.svh"

module ccar_regs #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    // direct register port
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              bit_wr,
    input  wire logic [2:0]        bit_sel,
    input  wire logic              bit_val,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   reg_hit,
    // stack operations
    input  wire logic              push_req,
    input  wire logic              pop_req,
    input  wire logic [7:0]        stack_rdata,
    output logic                   stack_we,
    output logic                   stack_re,
    output logic      [15:0]       stack_addr,
    output logic      [7:0]        stack_wdata,
    // program fetch from flash
    input  wire logic              fetch_req,
    input  wire logic [19:0]       fetch_pc,
    output logic                   fetch_ready,
    output logic      [19:0]       fetch_addr,
    output logic      [5:0]        fetch_page,
    output logic                   fetch_in_boot,
    output logic                   fetch_in_key,
    // vectors, xram and mode outputs
    input  wire logic [3:0]        vector_slot,
    output logic      [19:0]       vector_addr,
    input  wire logic [7:0]        port2_value,
    input  wire logic [7:0]        xram_low,
    output logic      [15:0]       xram_paged_addr,
    output logic      [19:0]       xram_base,
    output logic                   addr20_mode,
    output logic                   ext_stack_indicator,
    // info page erase guard
    input  wire logic              ifb_erase_req,
    input  wire logic [6:0]        ifb_offset,
    output logic                   ifb_erase_ok,
    output logic                   ifb_is_cal,
    // activity sources
    input  wire logic              high_prio_active,
    input  wire logic              low_prio_active,
    input  wire logic              uart1_tx_active,
    input  wire logic              uart1_rx_active,
    input  wire logic              uart0_tx_active,
    input  wire logic              uart0_rx_active
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]          work;
        logic [7:0]          aux;
        logic [7:0]          pflags;
        logic [7:0]          sp;
        logic [7:0]          sph;
        logic [7:0]          wait_st;
        logic [7:0]          xrel;
        logic [7:0]          actl;
        logic [7:0]          pagehi;
        logic [7:0]          act;
        logic [1:0]          key_st;
        logic [2:0]          key_cnt;
        ccar_pkg::ccar_fetch_t fst;
        logic [3:0]          wcnt;
        ccar_pkg::ccar_stack_t sop;
        logic [7:0]          rdata;
        logic                hit;
        logic                s_we;
        logic                s_re;
        logic [15:0]         s_addr;
        logic [7:0]          s_wdata;
        logic                f_rdy;
        logic [19:0]         f_addr;
        logic [5:0]          f_page;
        logic                f_boot;
        logic                f_key;
        logic [19:0]         v_addr;
        logic [15:0]         x_paged;
        logic                ifb_ok;
        logic                ifb_cal;
    } ccar_state_t;

    ccar_state_t st_q;
    ccar_state_t st_d;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // direct space decode, shared by reads and writes
    function automatic logic in_direct(input logic [ADDR_W-1:0] a);
        in_direct = a[7];
    endfunction

    // stack address in either mode
    function automatic logic [15:0] stk_addr(input logic m20, input logic [7:0] hi,
                                             input logic [7:0] lo);
        stk_addr = m20 ? {hi, lo} : {8'h00, lo};
    endfunction

    // flash page number of a program address
    function automatic logic [5:0] page_of(input logic [19:0] a);
        page_of = a[`CCAR_PAGE_SHIFT+5:`CCAR_PAGE_SHIFT];
    endfunction

    logic m20;
    logic ta_open;
    logic [15:0] sp_now;
    logic [7:0]  sp_inc;
    logic [7:0]  sp_dec;
    logic [15:0] sp16_inc;
    logic [15:0] sp16_dec;
    logic [7:0]  wdat;

    assign m20      = st_q.actl[`CCAR_ACTL_AMHI];
    assign ta_open  = (st_q.key_st == 2'd2);
    assign sp_now   = stk_addr(m20, st_q.sph, st_q.sp);
    assign sp16_inc = sp_now + 16'h0001;
    assign sp16_dec = sp_now - 16'h0001;
    assign sp_inc   = sp16_inc[7:0];
    assign sp_dec   = sp16_dec[7:0];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_d       = st_q;
        st_d.s_we  = 1'b0;
        st_d.s_re  = 1'b0;
        st_d.hit   = 1'b0;
        st_d.f_rdy = 1'b0;
        wdat       = reg_wdata[7:0];

        // activity flags track their sources; bus writes never touch them
        st_d.act = {1'b0, high_prio_active, low_prio_active, 1'b0, uart1_tx_active,
                    uart1_rx_active, uart0_tx_active, uart0_rx_active};

        // timed access key sequence
        if (st_q.key_cnt != 3'h0) begin
            st_d.key_cnt = st_q.key_cnt - 3'h1;
        end else if (st_q.key_st != 2'd0) begin
            st_d.key_st = 2'd0;
        end
        if (reg_wr && reg_addr[7:0] == `CCAR_OFF_TKEY1 && wdat == `CCAR_KEY1) begin
            st_d.key_st  = 2'd1;
            st_d.key_cnt = `CCAR_TA_WINDOW;
        end else if (reg_wr && reg_addr[7:0] == `CCAR_OFF_TKEY2 && wdat == `CCAR_KEY2
                     && st_q.key_st == 2'd1) begin
            st_d.key_st  = 2'd2;
            st_d.key_cnt = `CCAR_TA_WINDOW;
        end

        // byte writes in direct space
        if (reg_wr && in_direct(reg_addr)) begin
            unique case (reg_addr[7:0])
                `CCAR_OFF_WORK:   st_d.work   = wdat;
                `CCAR_OFF_AUX:    st_d.aux    = wdat;
                `CCAR_OFF_PFLAGS: st_d.pflags = wdat;
                `CCAR_OFF_SP:     st_d.sp     = wdat;
                `CCAR_OFF_SPH:    st_d.sph    = wdat;
                `CCAR_OFF_PAGEHI: st_d.pagehi = wdat;
                `CCAR_OFF_WAIT: begin
                    if (ta_open) begin
                        st_d.wait_st = wdat & `CCAR_WAIT_MASK;
                        st_d.key_st  = 2'd0;
                    end
                end
                `CCAR_OFF_XREL: begin
                    if (ta_open) begin
                        st_d.xrel   = wdat;
                        st_d.key_st = 2'd0;
                    end
                end
                `CCAR_OFF_ACTL: begin
                    if (ta_open) begin
                        // indicator bit is hardware owned
                        st_d.actl   = wdat & `CCAR_ACTL_WMASK;
                        st_d.key_st = 2'd0;
                    end
                end
                default: ;
            endcase
        end

        // single bit writes to the two bit addressable registers
        if (bit_wr && reg_addr[7:0] == `CCAR_OFF_WORK) begin
            st_d.work[bit_sel] = bit_val;
        end else if (bit_wr && reg_addr[7:0] == `CCAR_OFF_AUX) begin
            st_d.aux[bit_sel] = bit_val;
        end

        // indicator mirrors the selected addressing mode
        st_d.actl[`CCAR_ACTL_XSTK] = st_d.actl[`CCAR_ACTL_AMHI];

        // register reads
        if (reg_rd && in_direct(reg_addr)) begin
            st_d.hit = 1'b1;
            unique case (reg_addr[7:0])
                `CCAR_OFF_WORK:   st_d.rdata = st_q.work;
                `CCAR_OFF_AUX:    st_d.rdata = st_q.aux;
                `CCAR_OFF_PFLAGS: st_d.rdata = st_q.pflags;
                `CCAR_OFF_SP:     st_d.rdata = st_q.sp;
                `CCAR_OFF_SPH:    st_d.rdata = st_q.sph;
                `CCAR_OFF_WAIT:   st_d.rdata = st_q.wait_st;
                `CCAR_OFF_XREL:   st_d.rdata = st_q.xrel;
                `CCAR_OFF_ACTL:   st_d.rdata = st_q.actl;
                `CCAR_OFF_ACT:    st_d.rdata = st_q.act;
                `CCAR_OFF_PAGEHI: st_d.rdata = st_q.pagehi;
                default: begin
                    st_d.rdata = 8'h00;
                    st_d.hit   = 1'b0;
                end
            endcase
        end

        // stack: push pre-increments, pop reads then post-decrements
        unique case (st_q.sop)
            ccar_pkg::CCAR_S_NONE: begin
                if (push_req) begin
                    st_d.s_we    = 1'b1;
                    st_d.s_addr  = sp16_inc;
                    st_d.s_wdata = st_q.work;
                    st_d.sp      = sp_inc;
                    if (m20) begin
                        st_d.sph = sp16_inc[15:8];
                    end
                end else if (pop_req) begin
                    st_d.s_re   = 1'b1;
                    st_d.s_addr = sp_now;
                    st_d.sop    = ccar_pkg::CCAR_S_POP;
                end
            end
            ccar_pkg::CCAR_S_POP: begin
                st_d.work = stack_rdata;
                st_d.sp   = sp_dec;
                if (m20) begin
                    st_d.sph = sp16_dec[15:8];
                end
                st_d.sop = ccar_pkg::CCAR_S_NONE;
            end
            default: st_d.sop = ccar_pkg::CCAR_S_NONE;
        endcase

        // program fetch with wait states
        unique case (st_q.fst)
            ccar_pkg::CCAR_F_IDLE: begin
                if (fetch_req) begin
                    // 16-bit mode truncates the program counter
                    st_d.f_addr = m20 ? fetch_pc : {4'h0, fetch_pc[15:0]};
                    st_d.f_page = page_of(fetch_pc);
                    st_d.f_boot = page_of(fetch_pc) >= `CCAR_BOOT_PAGE0;
                    st_d.f_key  = fetch_pc >= `CCAR_KEY_FIRST
                                  && fetch_pc <= `CCAR_KEY_LAST;
                    st_d.wcnt   = st_q.wait_st[3:0];
                    st_d.fst    = (st_q.wait_st[3:0] == 4'h0) ? ccar_pkg::CCAR_F_DONE
                                                              : ccar_pkg::CCAR_F_WAIT;
                end
            end
            ccar_pkg::CCAR_F_WAIT: begin
                st_d.wcnt = st_q.wcnt - 4'h1;
                if (st_q.wcnt == 4'h1) begin
                    st_d.fst = ccar_pkg::CCAR_F_DONE;
                end
            end
            ccar_pkg::CCAR_F_DONE: begin
                st_d.f_rdy = 1'b1;
                st_d.fst   = ccar_pkg::CCAR_F_IDLE;
            end
            default: st_d.fst = ccar_pkg::CCAR_F_IDLE;
        endcase

        // vector base and paged xram high byte
        st_d.v_addr = (st_q.actl[`CCAR_ACTL_VEC] ? `CCAR_VEC_HI_BASE : 20'h00000)
                      + {13'h0000, vector_slot, 3'b011};
        st_d.x_paged = {st_q.actl[`CCAR_ACTL_PAGED] ? st_q.pagehi : port2_value,
                        xram_low};

        // info page: erase is never allowed; offsets up to 0x3f flag calibration
        st_d.ifb_ok  = 1'b0 & ifb_erase_req;
        st_d.ifb_cal = ifb_offset <= `CCAR_IFB_CAL_LAST;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q         <= '0;
            st_q.wait_st <= `CCAR_RST_WAIT;
            st_q.fst     <= ccar_pkg::CCAR_F_IDLE;
            st_q.sop     <= ccar_pkg::CCAR_S_NONE;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata           = st_q.rdata;
    assign reg_hit             = st_q.hit;
    assign stack_we            = st_q.s_we;
    assign stack_re            = st_q.s_re;
    assign stack_addr          = st_q.s_addr;
    assign stack_wdata         = st_q.s_wdata;
    assign fetch_ready         = st_q.f_rdy;
    assign fetch_addr          = st_q.f_addr;
    assign fetch_page          = st_q.f_page;
    assign fetch_in_boot       = st_q.f_boot;
    assign fetch_in_key        = st_q.f_key;
    assign vector_addr         = st_q.v_addr;
    assign xram_paged_addr     = st_q.x_paged;
    assign xram_base           = {st_q.xrel, 12'h000};
    assign addr20_mode         = st_q.actl[`CCAR_ACTL_AMHI];
    assign ext_stack_indicator = st_q.actl[`CCAR_ACTL_XSTK];
    assign ifb_erase_ok        = st_q.ifb_ok;
    assign ifb_is_cal          = st_q.ifb_cal;

endmodule // ccar_regs

`default_nettype wire

//--- dv/ccar_regs_checker.sv
// Purpose: port checks of the core register block
// Assumes: one clock, reset low and asynchronous
// Notes:   bound to every ccar_regs instance
`timescale 1ns/1ns
`default_nettype none
module ccar_regs_checker (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_hit,
    input wire logic        push_req,
    input wire logic        stack_we,
    input wire logic        stack_re,
    input wire logic [15:0] stack_addr,
    input wire logic        fetch_ready,
    input wire logic [19:0] fetch_addr,
    input wire logic [3:0]  vector_slot,
    input wire logic [19:0] vector_addr,
    input wire logic [7:0]  xram_low,
    input wire logic [15:0] xram_paged_addr,
    input wire logic [19:0] xram_base,
    input wire logic        addr20_mode,
    input wire logic        ext_stack_indicator,
    input wire logic        ifb_erase_ok,
    input wire logic        high_prio_active,
    input wire logic        low_prio_active,
    input wire logic        uart1_tx_active,
    input wire logic        uart1_rx_active,
    input wire logic        uart0_tx_active,
    input wire logic        uart0_rx_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // -----------------------------
    // sequences and assertions
    // -----------------------------
    sequence s_two_push;
        stack_we ##1 stack_we;
    endsequence
    sequence s_act_read; reg_rd && reg_addr == 8'hc5; endsequence
    AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h80 |=> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped read answered");
    AST_ACT_VIEW: assert property (s_act_read |=> reg_hit && reg_rdata == {1'b0,
        $past(high_prio_active, 2), $past(low_prio_active, 2), 1'b0, $past(uart1_tx_active, 2),
        $past(uart1_rx_active, 2), $past(uart0_tx_active, 2), $past(uart0_rx_active, 2)})
        else $error("activity byte wrong");
    AST_PUSH_GO: assert property (push_req && !stack_re |=> stack_we)
        else $error("push gave no write");
    AST_PUSH_STEP: assert property (s_two_push |-> stack_addr[7:0] == $past(stack_addr[7:0]) + 8'h01)
        else $error("push address not pre-incremented");
    AST_POP_ADDR: assert property ($past(stack_we) && stack_re |-> stack_addr == $past(stack_addr))
        else $error("pop not at current pointer");
    AST_STACK16: assert property ((stack_we || stack_re) && !addr20_mode |-> stack_addr[15:8] == 8'h00)
        else $error("narrow stack has high byte");
    AST_FETCH16: assert property (fetch_ready && !addr20_mode |-> fetch_addr[19:16] == 4'h0)
        else $error("16-bit fetch has upper bits");
    AST_XSTK_RO: assert property (ext_stack_indicator == addr20_mode)
        else $error("stack indicator off mode");
    AST_XBASE_STEP: assert property (xram_base[11:0] == 12'h000)
        else $error("xram base not 4KB aligned");
    AST_VEC_SLOT: assert property ($past(arst_n, 2) |-> vector_addr[6:0] == {$past(vector_slot), 3'h3})
        else $error("vector offset wrong");
    AST_PAGED_LOW: assert property ($past(arst_n, 2) |-> xram_paged_addr[7:0] == $past(xram_low))
        else $error("paged low byte wrong");
    AST_IFB_NOERASE: assert property (!ifb_erase_ok)
        else $error("info page erase allowed");
endmodule // ccar_regs_checker
bind ccar_regs ccar_regs_checker chk_u (.clk, .arst_n, .reg_rd, .reg_addr, .reg_rdata, .reg_hit,
    .push_req, .stack_we, .stack_re, .stack_addr, .fetch_ready, .fetch_addr, .vector_slot,
    .vector_addr, .xram_low, .xram_paged_addr, .xram_base, .addr20_mode, .ext_stack_indicator,
    .ifb_erase_ok, .high_prio_active, .low_prio_active, .uart1_tx_active, .uart1_rx_active,
    .uart0_tx_active, .uart0_rx_active);
`default_nettype wire

//--- dv/ccar_stack_ram.sv
// Purpose: internal data memory seen by the stack port
// Assumes: read data wanted while the read strobe stands
// Notes:   idle read data toggles so stale values never match
`timescale 1ns/1ns
`default_nettype none
module ccar_stack_ram (
    input  wire logic        clk,
    input  wire logic        stack_we,
    input  wire logic        stack_re,
    input  wire logic [15:0] stack_addr,
    input  wire logic [7:0]  stack_wdata,
    output logic      [7:0]  stack_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] rd_q = 8'h3c;
    // store pushes, answer pops while the read strobe stands
    always_ff @(posedge clk) begin
        if (stack_we) mem[stack_addr] <= stack_wdata;
        rd_q <= ~rd_q; // idle data keeps moving
    end
    assign stack_rdata = stack_re ? mem[stack_addr] : rd_q;
endmodule // ccar_stack_ram
`default_nettype wire

//--- dv/ccar_regs_tb.sv
// Purpose: directed tests of the core register block
// Assumes: key sequence and latencies as handed over
// Notes:   inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
`include "ccar_params.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module ccar_regs_tb;
    logic        clk, arst_n, reg_wr, reg_rd, bit_wr, bit_val, push_req, pop_req, fetch_req;
    logic        ifb_erase_req, reg_hit, stack_we, stack_re, fetch_ready, fetch_in_boot;
    logic        fetch_in_key, addr20_mode, ext_stack_indicator, ifb_erase_ok, ifb_is_cal;
    logic        high_prio_active, low_prio_active, uart1_tx_active, uart1_rx_active;
    logic        uart0_tx_active, uart0_rx_active;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, stack_rdata, stack_wdata, port2_value, xram_low;
    logic [2:0]  bit_sel;
    logic [3:0]  vector_slot;
    logic [5:0]  fetch_page;
    logic [6:0]  ifb_offset;
    logic [15:0] stack_addr, xram_paged_addr;
    logic [19:0] fetch_pc, fetch_addr, vector_addr, xram_base;
    logic [15:0] rst_tab [9] = '{16'h8100, 16'h9207, 16'h9b00, 16'h9d00, 16'hc500,
                                 16'hc600, 16'hd000, 16'he000, 16'hf000};
    logic [7:0]  w_tab [3] = '{8'h00, 8'h03, 8'hff};
    logic [19:0] pc_tab [4] = '{20'h17123, 20'h06ff8, 20'h06ff7, 20'h00010};
    logic [5:0]  act_tab [2] = '{6'h2a, 6'h15};
    int          n_mismatch = 0, check_count = 0, n;
    ccar_regs dut_u (.*);
    ccar_stack_ram ram_u (.clk, .stack_we, .stack_re, .stack_addr, .stack_wdata, .stack_rdata);
    // -----------------------------
    // clock, watchdog and bus tasks
    // -----------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        n_mismatch++;
        test_done();
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic bw(input logic [7:0] a, input logic [2:0] s, input logic v);
        @(negedge clk);
        {bit_wr, reg_addr, bit_sel, bit_val} = {1'b1, a, s, v};
        @(negedge clk);
        bit_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h = 1'b1);
        @(negedge clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk);
        reg_rd = 1'b0;
        `CHK($sformatf("reg %h", a), e, reg_rdata)
        `CHK("reg_hit", h, reg_hit)
    endtask
    task automatic prot(input logic [7:0] a, input logic [7:0] d);
        wr(`CCAR_OFF_TKEY1, `CCAR_KEY1);
        wr(`CCAR_OFF_TKEY2, `CCAR_KEY2);
        wr(a, d);
    endtask
    task automatic fetch(input logic [19:0] pc, output int k);
        @(negedge clk);
        {fetch_req, fetch_pc} = {1'b1, pc};
        @(negedge clk);
        fetch_req = 1'b0;
        k = 1;
        while (fetch_ready !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic push_one;
        @(negedge clk);
        push_req = 1'b1;
        @(negedge clk);
        push_req = 1'b0;
    endtask
    task automatic pop_one;
        @(negedge clk);
        pop_req = 1'b1;
        @(negedge clk);
        pop_req = 1'b0;
        @(negedge clk);
    endtask
    // -----------------------------
    // test sequence
    // -----------------------------
    initial begin
        {arst_n, reg_wr, reg_rd, bit_wr, bit_val, push_req, pop_req, fetch_req} = '0;
        {ifb_erase_req, high_prio_active, low_prio_active, uart1_tx_active} = '0;
        {uart1_rx_active, uart0_tx_active, uart0_rx_active, reg_addr, reg_wdata} = '0;
        {bit_sel, fetch_pc, ifb_offset} = '0;
        {port2_value, xram_low, vector_slot} = {8'h33, 8'h44, 4'h2};
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
        rd(8'h80, 8'h00, 1'b0);
        `CHK("vector_addr", 20'h00013, vector_addr)
        `CHK("xram_paged_addr", 16'h3344, xram_paged_addr)
        $display("test reset done");
        wr(8'h92, 8'h03);
        rd(8'h92, 8'h07);
        wr(8'hc5, 8'hff);
        rd(8'hc5, 8'h00);
        foreach (w_tab[i]) begin
            prot(8'h92, w_tab[i]);
            rd(8'h92, w_tab[i] & 8'h0f);
            fetch(20'h00100, n);
            `CHK("fetch latency", int'(w_tab[i][3:0]) + 2, n)
        end
        prot(8'h92, 8'h00);
        foreach (pc_tab[i]) begin
            fetch(pc_tab[i], n);
            `CHK("fetch_addr", {4'h0, pc_tab[i][15:0]}, fetch_addr)
            `CHK("fetch_page", pc_tab[i][14:9], fetch_page)
            `CHK("fetch_in_boot", pc_tab[i][14:9] >= 6'd56, fetch_in_boot)
            `CHK("fetch_in_key", pc_tab[i][15:3] == 13'h0dff, fetch_in_key)
        end
        $display("test wait states done");
        wr(8'hd0, 8'ha5);
        rd(8'hd0, 8'ha5);
        wr(8'he0, 8'h00);
        bw(8'he0, 3'h3, 1'b1);
        rd(8'he0, 8'h08);
        wr(8'hf0, 8'hff);
        bw(8'hf0, 3'h7, 1'b0);
        rd(8'hf0, 8'h7f);
        foreach (act_tab[i]) begin
            @(negedge clk);
            {high_prio_active, low_prio_active, uart1_tx_active, uart1_rx_active,
             uart0_tx_active, uart0_rx_active} = act_tab[i];
            rd(8'hc5, {1'b0, act_tab[i][5:4], 1'b0, act_tab[i][3:0]});
        end
        ifb_erase_req = 1'b1;
        ifb_offset = 7'h3f;
        @(negedge clk);
        `CHK("ifb_is_cal", 1'b1, ifb_is_cal)
        ifb_offset = 7'h40;
        @(negedge clk);
        `CHK("ifb_is_cal", 1'b0, ifb_is_cal)
        $display("test registers done");
        wr(8'h81, 8'h10);
        wr(8'he0, 8'ha5);
        push_one();
        wr(8'he0, 8'h5a);
        @(negedge clk);
        push_req = 1'b1;
        @(negedge clk);
        `CHK("stack_addr", 16'h0012, stack_addr)
        `CHK("stack_wdata", 8'h5a, stack_wdata)
        {push_req, pop_req} = 2'b01;
        @(negedge clk);
        `CHK("stack_addr", 16'h0012, stack_addr)
        `CHK("stack_re", 1'b1, stack_re)
        pop_req = 1'b0;
        @(negedge clk);
        rd(8'he0, 8'h5a);
        pop_one();
        rd(8'he0, 8'ha5);
        rd(8'h81, 8'h10);
        $display("test stack done");
        prot(8'h9d, 8'h04);
        `CHK("ext_stack_indicator", 1'b0, ext_stack_indicator)
        wr(8'hda, 8'h5a);
        prot(8'h9d, 8'h2a);
        prot(8'hc6, 8'h01);
        `CHK("addr20_mode", 1'b1, addr20_mode)
        `CHK("vector_addr", 20'h07013, vector_addr)
        `CHK("xram_paged_addr", 16'h5a44, xram_paged_addr)
        `CHK("xram_base", 20'h01000, xram_base)
        prot(8'hc6, 8'h00);
        `CHK("xram_base", 20'h00000, xram_base)
        fetch(20'h17123, n);
        `CHK("fetch_addr", 20'h17123, fetch_addr)
        wr(8'h9b, 8'h12);
        @(negedge clk);
        push_req = 1'b1;
        repeat (2) @(negedge clk);
        push_req = 1'b0;
        `CHK("stack_addr", 16'h1212, stack_addr)
        $display("test wide mode done");
        test_done();
    end
endmodule // ccar_regs_tb
`default_nettype wire
